/* dv/gate_driver_safety_supervisor_monitor.sv */
// Purpose: concurrent checks on the supervisor ports
// Assumes: single clock domain, nrst active low
// Notes: pin paths get up to 8 cycles of latency
`include "gds_map.vh"
module gate_driver_safety_supervisor_monitor (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // stimulus side
  input wire primary_undervoltage_lockout,
  input wire counterpart_pwm_input,
  input wire [`DEAD_W-1:0] interlock_dead_time_field,
  input wire cmd_valid,
  input wire cmd_format_error,
  input wire clear_crossconduction,
  input wire [`LEVEL_W-1:0] turn_on_plateau_level,
  input wire booster_diode_compensation_bit,
  // design side
  input wire reset_ready_pin,
  input wire primary_reset_flag,
  input wire crossconduction_error_flag,
  input wire serial_command_error_flag,
  input wire [4:0] operating_state,
  input wire pwm_out,
  input wire reduced_gate_turn_on,
  input wire [`LEVEL_W-1:0] turn_on_level_output
);
  reg cp_q;
  reg [3:0] hi_q;
  reg [7:0] lo_q;
  reg [4:0] st_q;
  reg [14:0] tmo_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // counterpart high/low run lengths and test state dwell
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cp_q <= 1'b0;
      hi_q <= 4'h0;
      lo_q <= 8'hFF;
      st_q <= 5'h00;
      tmo_q <= 15'h0000;
    end else begin
      cp_q <= counterpart_pwm_input;
      lo_q <= counterpart_pwm_input ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
      hi_q <= !counterpart_pwm_input ? hi_q : !cp_q ? 4'h1 : hi_q + {3'h0, !hi_q[3]};
      st_q <= operating_state;
      tmo_q <= (st_q == operating_state && (operating_state[3] || operating_state[4])) ? tmo_q + 15'h0001 : 15'h0000;
    end
  end
  ready_low_a: assert property (primary_undervoltage_lockout [*8] |-> !reset_ready_pin)
    else $error("ready high during primary undervoltage");
  reset_flag_a: assert property ($rose(reset_ready_pin) |-> primary_reset_flag)
    else $error("ready released without reset flag");
  pwm_block_a: assert property (counterpart_pwm_input [*8] |-> !pwm_out)
    else $error("pwm passed while counterpart on");
  dead_time_a: assert property (!counterpart_pwm_input && hi_q[3]
    && lo_q < `DEAD_MIN_CYC + `DEAD_STEP_CYC * interlock_dead_time_field |-> !pwm_out)
    else $error("pwm passed inside dead time");
  spi_error_a: assert property (cmd_valid && cmd_format_error |=> serial_command_error_flag)
    else $error("bad frame did not flag");
  xc_latch_a: assert property ($fell(crossconduction_error_flag) |-> $past(clear_crossconduction))
    else $error("crossconduction flag dropped without clear");
  weak_gate_a: assert property (reduced_gate_turn_on == (operating_state == `ST_WEAK))
    else $error("reduced turn-on outside weak state");
  ton_level_a: assert property (($stable(turn_on_plateau_level) && $stable(booster_diode_compensation_bit)) [*6]
    |-> turn_on_level_output == (!booster_diode_compensation_bit ? turn_on_plateau_level
    : (turn_on_plateau_level > `VBE_DROP) ? turn_on_plateau_level - `VBE_DROP : 8'h00))
    else $error("turn-on level wrong");
  test_timeout_a: assert property (tmo_q <= `TIMEOUT_CYC + 4)
    else $error("test state outlived time-out");
endmodule

/* dv/gate_driver_safety_supervisor_tb.sv */
// Purpose: directed checks of the gate driver safety supervisor
// Assumes: time-out define at its full value
// Notes: expectations derive from header constants and literal values
`include "gds_map.vh"
module gate_driver_safety_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, nrst = 1'b0, primary_undervoltage_lockout = 1'b0, secondary_uv_low_level = 1'b0;
  logic secondary_uv_high_level = 1'b0, secondary_reset_comparator = 1'b0, parity_check_enable = 1'b1;
  logic secondary_undervoltage_level_select = 1'b0, pwm_command_input = 1'b0, counterpart_pwm_input = 1'b0;
  logic booster_diode_compensation_bit = 1'b0, clear_primary_reset = 1'b0, clear_secondary_uv = 1'b0;
  logic clear_crossconduction = 1'b0, clear_serial_error = 1'b0;
  logic [`DEAD_W-1:0] interlock_dead_time_field = 4'h0;
  logic [`LEVEL_W-1:0] turn_on_plateau_level = 8'h40;
  wire cmd_valid, cmd_format_error, cmd_parity_bad, reset_ready_pin, fault_b_pin, primary_reset_flag;
  wire secondary_undervoltage_error_flag, secondary_undervoltage_live_status, crossconduction_error_flag;
  wire crossconduction_status_bit, serial_command_error_flag, pwm_out, reduced_gate_turn_on, secondary_in_reset;
  wire [2:0] cmd_code;
  wire [7:0] cmd_data, turn_on_level_output;
  wire [4:0] operating_state;
  wire [3:0] primary_supervision_control, secondary_supervision_control;
  wire [3:0] active_primary_supervision, active_secondary_supervision;
  int num_errors = 0, check_count = 0;
  // frame code, format error, parity bad, parity enable, expected flag
  logic [6:0] spi_tbl [6] = '{7'h03, 7'h73, 7'h5B, 7'h57, 7'h54, 7'h12};
  gate_driver_safety_supervisor gate_driver_safety_supervisor_i (.*);
  host_mcu_model host_mcu_model_i (.*);
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // flag clear pulses: primary, secondary, crossconduction, serial
  task clr(input logic [3:0] m);
    @(posedge core_clk);
    {clear_primary_reset, clear_secondary_uv, clear_crossconduction, clear_serial_error} <= m;
    @(posedge core_clk);
    {clear_primary_reset, clear_secondary_uv, clear_crossconduction, clear_serial_error} <= 4'h0;
  endtask
  task go(input logic [2:0] c, input logic [4:0] e);
    host_mcu_model_i.send(c, 8'h00, 1'b0, 1'b0);
    wt(3);
    chk("state", operating_state, e);
  endtask
  task end_of_test;
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    wt(8);
    chk("ready", reset_ready_pin, 1'b1);
    chk("rst_flag", primary_reset_flag, 1'b1);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      parity_check_enable <= spi_tbl[i][1];
      host_mcu_model_i.send(spi_tbl[i][6:4], 8'h00, spi_tbl[i][3], spi_tbl[i][2]);
      wt(2);
      chk("spi_err", serial_command_error_flag, spi_tbl[i][0]);
      clr(4'h1);
    end
    go(`CMD_VERIFY, `ST_CONFIG);
    host_mcu_model_i.prepare_test(4'h2, 4'h0);
    go(`CMD_VERIFY, `ST_VERIFY);
    chk("sel", active_primary_supervision, 4'h2);
    chk("sel2", active_secondary_supervision, 4'h0);
    chk("plateau", host_mcu_model_i.safe_plateau_value, 8'h00);
    go(`CMD_WEAK, `ST_WEAK);
    chk("weak", reduced_gate_turn_on, 1'b1);
    wt(20010);
    chk("timeout", operating_state, `ST_IDLE);
    chk("sel_off", active_primary_supervision, 4'h0);
    go(`CMD_CONFIG, `ST_CONFIG);
    host_mcu_model_i.prepare_test(4'h0, 4'h3);
    go(`CMD_VERIFY, `ST_VERIFY);
    chk("sel2_on", active_secondary_supervision, 4'h3);
    go(`CMD_IDLE, `ST_IDLE);
    chk("sel_clr", active_secondary_supervision, 4'h0);
    go(`CMD_CONFIG, `ST_CONFIG);
    go(`CMD_ACTIVE, `ST_ACTIVE);
    go(`CMD_VERIFY, `ST_ACTIVE);
    @(posedge core_clk);
    interlock_dead_time_field <= 4'h1;
    counterpart_pwm_input <= 1'b1;
    wt(10);
    chk("xc_status", crossconduction_status_bit, 1'b1);
    @(posedge core_clk);
    pwm_command_input <= 1'b1;
    repeat (2) @(posedge core_clk);
    pwm_command_input <= 1'b0;
    wt(10);
    chk("xc_glitch", crossconduction_error_flag, 1'b0);
    @(posedge core_clk);
    pwm_command_input <= 1'b1;
    wt(8);
    chk("pwm_block", pwm_out, 1'b0);
    chk("xc_flag", crossconduction_error_flag, 1'b1);
    @(posedge core_clk);
    counterpart_pwm_input <= 1'b0;
    wt(9);
    chk("dead", pwm_out, 1'b0);
    wt(10);
    chk("pwm_pass", pwm_out, 1'b1);
    chk("xc_status_off", crossconduction_status_bit, 1'b0);
    chk("xc_held", crossconduction_error_flag, 1'b1);
    clr(4'h2);
    wt(2);
    chk("xc_clear", crossconduction_error_flag, 1'b0);
    @(posedge core_clk);
    secondary_undervoltage_level_select <= 1'b1;
    secondary_uv_low_level <= 1'b1;
    wt(8);
    chk("uv_flag", secondary_undervoltage_error_flag, 1'b1);
    chk("fault_b", fault_b_pin, 1'b0);
    chk("uv_off", pwm_out, 1'b0);
    chk("uv_live", secondary_undervoltage_live_status, 1'b1);
    @(posedge core_clk);
    secondary_undervoltage_level_select <= 1'b0;
    wt(8);
    chk("uv_sel", secondary_undervoltage_live_status, 1'b0);
    chk("uv_held", secondary_undervoltage_error_flag, 1'b1);
    @(posedge core_clk);
    secondary_uv_low_level <= 1'b0;
    clr(4'h4);
    wt(2);
    chk("uv_clear", secondary_undervoltage_error_flag, 1'b0);
    chk("fault_rel", fault_b_pin, 1'b1);
    go(`CMD_CONFIG, `ST_CONFIG);
    go(`CMD_ACTIVE, `ST_ACTIVE);
    clr(4'h8);
    wt(2);
    chk("rst_clr", primary_reset_flag, 1'b0);
    @(posedge core_clk);
    primary_undervoltage_lockout <= 1'b1;
    wt(8);
    chk("ready_low", reset_ready_pin, 1'b0);
    chk("uv1_off", pwm_out, 1'b0);
    @(posedge core_clk);
    primary_undervoltage_lockout <= 1'b0;
    wt(8);
    chk("ready_back", reset_ready_pin, 1'b1);
    chk("rst_set", primary_reset_flag, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      secondary_reset_comparator <= !i;
      booster_diode_compensation_bit <= !i;
      wt(8);
      chk("sec_reset", secondary_in_reset, !i);
      chk("ton", turn_on_level_output, (i == 0) ? 8'h40 - `VBE_DROP : 8'h40);
    end
    end_of_test();
  end
endmodule
bind gate_driver_safety_supervisor gate_driver_safety_supervisor_monitor gate_driver_safety_supervisor_monitor_i (.*);

/* dv/host_mcu_model.sv */
// Purpose: host side model sending decoded frames and test selections
// Assumes: frames launched on rising core_clk edges
// Notes: idle data lines show the inverted last value
`include "gds_map.vh"
module host_mcu_model (
  // clock
  input wire core_clk,
  // decoded serial frame
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [7:0] cmd_data,
  output logic cmd_format_error,
  output logic cmd_parity_bad,
  // supervision selections
  output logic [3:0] primary_supervision_control,
  output logic [3:0] secondary_supervision_control
);
  logic [7:0] safe_plateau_value;
  // quiet bus at time zero
  initial begin
    {cmd_valid, cmd_code, cmd_data, cmd_format_error, cmd_parity_bad} = 14'h0000;
    {primary_supervision_control, secondary_supervision_control} = 8'h00;
    safe_plateau_value = 8'h20;
  end
  // one frame, held for one clock then released
  task send(input logic [2:0] c, input logic [7:0] d, input logic f, input logic p);
    @(posedge core_clk);
    {cmd_valid, cmd_code, cmd_data, cmd_format_error, cmd_parity_bad} <= {1'b1, c, d, f, p};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    {cmd_code, cmd_data, cmd_format_error, cmd_parity_bad} <= ~{c, d, f, p};
  endtask
  // unlock keys, then primary and secondary selections and zero safe plateau
  task prepare_test(input logic [3:0] ps, input logic [3:0] ss);
    send(`CMD_UNLOCK, `UNLOCK_KEY_1, 1'b0, 1'b0);
    send(`CMD_UNLOCK, `UNLOCK_KEY_2, 1'b0, 1'b0);
    primary_supervision_control <= ps;
    secondary_supervision_control <= ss;
    safe_plateau_value <= 8'h00;
  endtask
endmodule

/* hdl/crossconduction_interlock.v */
// Purpose: counterpart pwm interlock with dead time and glitch filter
// Assumes: inputs already synchronised to core_clk
// Notes: violation flag pulse is one cycle wide
`include "gds_map.vh"
module crossconduction_interlock (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // pwm inputs
  input wire counterpart_on,
  input wire command_on,
  input wire [`DEAD_W-1:0] interlock_dead_time_field,
  // results
  output reg pwm_gated_q,
  output reg inhibit_q,
  output reg violation_q
);
  reg [`CNT_W-1:0] dead_cnt_q;
  reg [`FILT_W-1:0] filt_cnt_q;
  wire [31:0] dead_sum;
  wire [`CNT_W-1:0] dead_load;
  wire inhibit_now;
  wire conflict;

  // dead time is the hardware floor plus the configured extension
  assign dead_sum = `DEAD_MIN_CYC + interlock_dead_time_field * `DEAD_STEP_CYC;
  assign dead_load = dead_sum[`CNT_W-1:0]; // count fits the counter width
  assign inhibit_now = counterpart_on | (dead_cnt_q != {`CNT_W{1'b0}});
  assign conflict = inhibit_now & command_on;

  // dead time counter restarts while counterpart stays on
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dead_cnt_q <= {`CNT_W{1'b0}};
    end else if (counterpart_on) begin
      dead_cnt_q <= dead_load;
    end else if (dead_cnt_q != {`CNT_W{1'b0}}) begin
      dead_cnt_q <= dead_cnt_q - 1'b1;
    end
  end

  // gating and filtered violation detection
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_gated_q <= 1'b0;
      inhibit_q <= 1'b0;
      violation_q <= 1'b0;
      filt_cnt_q <= {`FILT_W{1'b0}};
    end else begin
      pwm_gated_q <= command_on & ~inhibit_now;
      inhibit_q <= inhibit_now;
      violation_q <= 1'b0;
      if (!conflict) begin
        filt_cnt_q <= {`FILT_W{1'b0}};
      end else if (filt_cnt_q < `GLITCH_CYC) begin
        filt_cnt_q <= filt_cnt_q + 1'b1;
      end else if (filt_cnt_q == `GLITCH_CYC) begin
        filt_cnt_q <= filt_cnt_q + 1'b1;
        violation_q <= 1'b1;
      end
    end
  end
endmodule

/* hdl/gate_driver_safety_supervisor.v */
// Purpose: supply lockout, interlock, serial error and test state supervision
// Assumes: comparator and pin inputs are asynchronous; command strobes are on core_clk
// Notes: flags clear by one-cycle clear strobes; set wins over clear
// Operation
// - primary undervoltage: regular turn-off, ready low
// - primary recovery: release ready, set reset flag
// - secondary undervoltage: turn-off, flag, fault on change
// - secondary recovery removes error, output re-enablable
// - level select chooses secondary undervoltage threshold
// - live secondary detector state as status
// - secondary logic reset below reset threshold
// - counterpart on inhibits own pwm input
// - dead time after counterpart off, configurable
// - pwm during inhibition ignored, flag set
// - conflicts under 50 ns are filtered
// - interlock always on, status bit reflects it
// - invalid serial commands flag error, parity optional
// - tests need unlock sequence, refused when active
// - test states time out back to idle
// - supervision selections latch on verification entry
// - reduced gate turn-on exactly in weak state
// - compensation bit subtracts one diode drop
`include "gds_map.vh"
module gate_driver_safety_supervisor (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // supply comparators
  input wire primary_undervoltage_lockout,
  input wire secondary_uv_low_level,
  input wire secondary_uv_high_level,
  input wire secondary_reset_comparator,
  input wire secondary_undervoltage_level_select,
  // pwm pins
  input wire pwm_command_input,
  input wire counterpart_pwm_input,
  input wire [`DEAD_W-1:0] interlock_dead_time_field,
  // serial command port, decoded frames
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire [7:0] cmd_data,
  input wire cmd_format_error,
  input wire cmd_parity_bad,
  input wire parity_check_enable,
  // configuration
  input wire [3:0] primary_supervision_control,
  input wire [3:0] secondary_supervision_control,
  input wire [`LEVEL_W-1:0] turn_on_plateau_level,
  input wire booster_diode_compensation_bit,
  // flag clears
  input wire clear_primary_reset,
  input wire clear_secondary_uv,
  input wire clear_crossconduction,
  input wire clear_serial_error,
  // status
  output reg reset_ready_pin,
  output reg fault_b_pin,
  output reg primary_reset_flag,
  output reg secondary_undervoltage_error_flag,
  output reg secondary_undervoltage_live_status,
  output reg crossconduction_error_flag,
  output reg crossconduction_status_bit,
  output reg serial_command_error_flag,
  output reg [4:0] operating_state,
  output reg [3:0] active_primary_supervision,
  output reg [3:0] active_secondary_supervision,
  // output stage
  output reg pwm_out,
  output reg reduced_gate_turn_on,
  output reg [`LEVEL_W-1:0] turn_on_level_output,
  output reg secondary_in_reset
);
  reg rst_s1_q, rst_n_q;
  reg [2:0] uv1_sync_q, uv2l_sync_q, uv2h_sync_q, rst2_sync_q, inp_sync_q, counterpart_pwm_input_sync_q;
  reg uv1_q, uv2l_q, uv2h_q, rst2_q, inp_q, counterpart_pwm_input_q;
  reg uv2_err_q;
  reg [4:0] state_q, state_d;
  reg [1:0] unlock_q;
  reg [`CNT_W-1:0] tmo_q;
  reg cmd_bad;
  wire pwm_gated, inhibit, violation, uv2_trip, unlocked, tmo_done;

  // stable level once second and third stage agree
  function filt;
    input [2:0] s;
    input cur;
    begin
      filt = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  // reset release through two flip-flops
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // three-stage synchronisers for pin and comparator inputs
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      uv1_sync_q <= 3'h0;
      uv2l_sync_q <= 3'h0;
      uv2h_sync_q <= 3'h0;
      rst2_sync_q <= 3'h0;
      inp_sync_q <= 3'h0;
      counterpart_pwm_input_sync_q <= 3'h0;
      uv1_q <= 1'b0;
      uv2l_q <= 1'b0;
      uv2h_q <= 1'b0;
      rst2_q <= 1'b0;
      inp_q <= 1'b0;
      counterpart_pwm_input_q <= 1'b0;
    end else begin
      uv1_sync_q <= {uv1_sync_q[1:0], primary_undervoltage_lockout};
      uv2l_sync_q <= {uv2l_sync_q[1:0], secondary_uv_low_level};
      uv2h_sync_q <= {uv2h_sync_q[1:0], secondary_uv_high_level};
      rst2_sync_q <= {rst2_sync_q[1:0], secondary_reset_comparator};
      inp_sync_q <= {inp_sync_q[1:0], pwm_command_input};
      counterpart_pwm_input_sync_q <= {counterpart_pwm_input_sync_q[1:0], counterpart_pwm_input};
      uv1_q <= filt(uv1_sync_q, uv1_q);
      uv2l_q <= filt(uv2l_sync_q, uv2l_q);
      uv2h_q <= filt(uv2h_sync_q, uv2h_q);
      rst2_q <= filt(rst2_sync_q, rst2_q);
      inp_q <= filt(inp_sync_q, inp_q);
      counterpart_pwm_input_q <= filt(counterpart_pwm_input_sync_q, counterpart_pwm_input_q);
    end
  end

  // threshold choice for the secondary detector
  assign uv2_trip = secondary_undervoltage_level_select ? uv2l_q : uv2h_q;
  assign unlocked = unlock_q == 2'h2;
  assign tmo_done = tmo_q == `TIMEOUT_CYC;

  crossconduction_interlock u_interlock (
    .core_clk(core_clk),
    .rst_n(rst_n_q),
    .counterpart_on(counterpart_pwm_input_q),
    .command_on(inp_q),
    .interlock_dead_time_field(interlock_dead_time_field),
    .pwm_gated_q(pwm_gated),
    .inhibit_q(inhibit),
    .violation_q(violation)
  );

  // invalid serial command detection
  always @* begin
    cmd_bad = 1'b0;
    if (cmd_valid) begin
      cmd_bad = cmd_format_error | (parity_check_enable & cmd_parity_bad);
      if (cmd_code == 3'h0 || cmd_code == 3'h7) begin
        cmd_bad = 1'b1;
      end
    end
  end

  // operating state transitions
  always @* begin
    state_d = state_q;
    if (uv1_q || uv2_err_q) begin
      state_d = `ST_IDLE;
    end else if ((state_q == `ST_VERIFY || state_q == `ST_WEAK) && tmo_done) begin
      state_d = `ST_IDLE;
    end else if (cmd_valid && !cmd_bad) begin
      case (state_q)
        `ST_IDLE: if (cmd_code == `CMD_CONFIG) state_d = `ST_CONFIG;
        `ST_CONFIG: begin
          if (cmd_code == `CMD_ACTIVE) state_d = `ST_ACTIVE;
          else if (cmd_code == `CMD_VERIFY && unlocked) state_d = `ST_VERIFY;
        end
        `ST_ACTIVE: if (cmd_code == `CMD_IDLE) state_d = `ST_IDLE; // tests refused while active
        `ST_VERIFY: begin
          if (cmd_code == `CMD_WEAK) state_d = `ST_WEAK;
          else if (cmd_code == `CMD_IDLE) state_d = `ST_IDLE;
        end
        `ST_WEAK: if (cmd_code == `CMD_IDLE) state_d = `ST_IDLE;
        default: state_d = `ST_IDLE;
      endcase
    end
  end

  // state, unlock sequence, time-out and supervision selections
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= `ST_IDLE;
      unlock_q <= 2'h0;
      tmo_q <= {`CNT_W{1'b0}};
      active_primary_supervision <= 4'h0;
      active_secondary_supervision <= 4'h0;
    end else begin
      state_q <= state_d;
      if (cmd_valid && !cmd_bad && cmd_code == `CMD_UNLOCK) begin
        if (unlock_q == 2'h0 && cmd_data == `UNLOCK_KEY_1) unlock_q <= 2'h1;
        else if (unlock_q == 2'h1 && cmd_data == `UNLOCK_KEY_2) unlock_q <= 2'h2;
        else if (unlock_q != 2'h2) unlock_q <= 2'h0;
      end
      if (state_d == `ST_VERIFY || state_d == `ST_WEAK) begin
        if (!tmo_done) tmo_q <= tmo_q + 1'b1;
      end else begin
        tmo_q <= {`CNT_W{1'b0}};
      end
      if (state_q == `ST_CONFIG && state_d == `ST_VERIFY) begin
        active_primary_supervision <= primary_supervision_control;
        active_secondary_supervision <= secondary_supervision_control;
      end else if (state_d != `ST_VERIFY && state_d != `ST_WEAK) begin
        active_primary_supervision <= 4'h0;
        active_secondary_supervision <= 4'h0;
      end
    end
  end

  // latched error flags, set beats clear
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      uv2_err_q <= 1'b0;
      primary_reset_flag <= 1'b1;
      secondary_undervoltage_error_flag <= 1'b0;
      crossconduction_error_flag <= 1'b0;
      serial_command_error_flag <= 1'b0;
    end else begin
      uv2_err_q <= uv2_trip;
      if (uv1_q) primary_reset_flag <= 1'b1;
      else if (clear_primary_reset) primary_reset_flag <= 1'b0;
      if (uv2_trip) secondary_undervoltage_error_flag <= 1'b1;
      else if (clear_secondary_uv) secondary_undervoltage_error_flag <= 1'b0;
      if (violation) crossconduction_error_flag <= 1'b1;
      else if (clear_crossconduction) crossconduction_error_flag <= 1'b0;
      if (cmd_bad) serial_command_error_flag <= 1'b1;
      else if (clear_serial_error) serial_command_error_flag <= 1'b0;
    end
  end

  // pins and output stage
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reset_ready_pin <= 1'b0;
      fault_b_pin <= 1'b1;
      secondary_undervoltage_live_status <= 1'b0;
      crossconduction_status_bit <= 1'b0;
      operating_state <= `ST_IDLE;
      pwm_out <= 1'b0;
      reduced_gate_turn_on <= 1'b0;
      turn_on_level_output <= {`LEVEL_W{1'b0}};
      secondary_in_reset <= 1'b1;
    end else begin
      reset_ready_pin <= ~uv1_q;
      if (uv2_trip && state_q != `ST_IDLE) fault_b_pin <= 1'b0;
      else if (!secondary_undervoltage_error_flag) fault_b_pin <= 1'b1;
      secondary_undervoltage_live_status <= uv2_trip;
      crossconduction_status_bit <= inhibit;
      operating_state <= state_q;
      pwm_out <= pwm_gated & (state_q == `ST_ACTIVE || state_q == `ST_WEAK) & ~uv1_q & ~uv2_err_q;
      reduced_gate_turn_on <= (state_q == `ST_WEAK);
      if (booster_diode_compensation_bit) begin
        turn_on_level_output <= (turn_on_plateau_level > `VBE_DROP) ?
          turn_on_plateau_level - `VBE_DROP : {`LEVEL_W{1'b0}};
      end else begin
        turn_on_level_output <= turn_on_plateau_level;
      end
      secondary_in_reset <= rst2_q;
    end
  end
endmodule

/* hdl/gds_map.vh */
`ifndef GDS_MAP_VH
`define GDS_MAP_VH
// operating states, one-hot
`define ST_IDLE 5'h01
`define ST_CONFIG 5'h02
`define ST_ACTIVE 5'h04
`define ST_VERIFY 5'h08
`define ST_WEAK 5'h10
// interlock timing (clock 40 MHz, 25 ns)
`define CLK_PERIOD_NS 25
`define GLITCH_NS 50
`define GLITCH_CYC ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_MIN_NS 100
`define DEAD_MIN_CYC ((`DEAD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_STEP_CYC 4
// test state time-out
`define TIMEOUT_CYC 20000
// serial unlock sequence
`define UNLOCK_KEY_1 8'hA5
`define UNLOCK_KEY_2 8'h5A
// command codes
`define CMD_CONFIG 3'h1
`define CMD_ACTIVE 3'h2
`define CMD_VERIFY 3'h3
`define CMD_WEAK 3'h4
`define CMD_IDLE 3'h5
`define CMD_UNLOCK 3'h6
// field widths and levels
`define DEAD_W 4
`define LEVEL_W 8
`define VBE_DROP 8'h08
`define CNT_W 15
`define FILT_W 3
`endif
